// ### shared/wcs_regs.svh
// Register offsets, control bits, cycle mode codes and timing counts.
// Assumes a 200 MHz system clock and a byte-addressed register port.
`ifndef WCS_REGS_SVH
`define WCS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WCS_CTRL_OFS   12'h000
`define WCS_STAT_OFS   12'h004
`define WCS_KEY_OFS    12'h008
`define WCS_TAB_OFS    12'h400

// ----------------------------------------------------------------------
// Control bits and reset values
// ----------------------------------------------------------------------
`define WCS_CTRL_WELD  0
`define WCS_CTRL_EXT   1
`define WCS_CTRL_RST   2'h0
`define WCS_KEY_RST    7'h00

// ----------------------------------------------------------------------
// Cycle mode codes, schedule count and auxiliary schedule numbers
// ----------------------------------------------------------------------
`define WCS_CM_NONREP  3'h0
`define WCS_CM_REPEAT  3'h1
`define WCS_CM_CHAIN   3'h2
`define WCS_CM_SUCC    3'h3
`define WCS_CM_CSUCC   3'h4
`define WCS_CM_WAIT    3'h5
`define WCS_NUM_SCHED  100
`define WCS_AUX_A      7'h0A
`define WCS_AUX_B      7'h14

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WCS_CLK_KHZ    200000
`define WCS_BS_HOLD_MS 1500
`define WCS_BS_HOLD_CYC (`WCS_BS_HOLD_MS * `WCS_CLK_KHZ)

`endif

// ### shared/wcs_pkg.sv
// Types shared by the weld cycle sequencer and its bench.
// Assumes schedule numbers fit in seven bits.
`default_nettype none
package wcs_pkg;

    typedef enum logic [3:0] {
        st_idle, st_sqz, st_weld, st_cool, st_hold, st_off, st_csw, st_whw
    } wcs_state_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] valves;
        logic [7:0] cur;
        logic [7:0] imp;
        logic [7:0] cool;
        logic [7:0] off;
        logic [7:0] hold;
        logic [7:0] weld;
        logic [7:0] sqz;
    } wcs_sched_t;

    typedef struct packed {
        logic ext_sel;
        logic weld_en;
    } wcs_ctrl_t;

    typedef struct packed {
        logic init;
        logic press;
        logic back_step_input;
        logic aux_initiation_first;
        logic aux_initiation_second;
        logic schedule_select_bit_a;
        logic schedule_select_bit_b;
        logic line_tick;
    } wcs_oper_t;

    typedef struct packed {
        logic [4:0] valves;
        logic       fire;
        logic [7:0] level;
    } wcs_drive_t;

    typedef struct packed {
        logic [6:0] sched;
        logic       flash;
        logic       sqz_flash;
        logic       hold_flash;
        logic       err06;
    } wcs_disp_t;

endpackage

`default_nettype wire

// ### hdl/wcs_sequencer.sv
// Weld schedule sequencer with its schedule table and register port.
// Assumes operator inputs synchronous to mclk and one line_tick per line cycle.
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "wcs_regs.svh"

module wcs_sequencer #(
    parameter int          NUM_SCHED   = `WCS_NUM_SCHED,
    parameter logic [31:0] BS_HOLD_CYC = 32'(`WCS_BS_HOLD_CYC)
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // Register port
    input  wire logic [11:0]        avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    // Machine side
    input  wire wcs_pkg::wcs_oper_t oper,
    output wcs_pkg::wcs_drive_t     drive,
    output wcs_pkg::wcs_disp_t      disp
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SCHED-1:0][63:0] tab;
        wcs_pkg::wcs_ctrl_t         ctl;
        logic [6:0]                 key;
        wcs_pkg::wcs_state_t        st;
        logic [6:0]                 cur;
        logic [6:0]                 first;
        logic [6:0]                 sfirst;
        logic                       series;
        logic [7:0]                 cnt;
        logic [7:0]                 imp;
        logic                       need_rel;
        logic                       init_q;
        logic                       bs_q;
        logic [31:0]                bs_cnt;
        wcs_pkg::wcs_drive_t        drv;
        wcs_pkg::wcs_disp_t         dsp;
        logic                       wreq;
        logic [31:0]                rdata;
    } wcs_seq_state_t;

    localparam wcs_seq_state_t S_RST = '{
        ctl:     wcs_pkg::wcs_ctrl_t'(`WCS_CTRL_RST),
        key:     `WCS_KEY_RST,
        st:      wcs_pkg::st_idle,
        wreq:    1'b1,
        default: '0
    };

    wcs_seq_state_t      s;
    wcs_seq_state_t      next_s;
    wcs_pkg::wcs_sched_t cs;
    logic [6:0]          nxt;
    logic [6:0]          ss;
    logic                rise;
    logic [11:0]         toff;
    logic [8:0]          ti;
    logic                thit;

    assign cs   = wcs_pkg::wcs_sched_t'(s.tab[s.cur]);
    assign nxt  = (s.cur >= 7'(NUM_SCHED - 1)) ? 7'h00 : 7'(s.cur + 7'h01);
    assign ss   = {5'h00, oper.schedule_select_bit_b, oper.schedule_select_bit_a};
    assign rise = oper.init & ~s.init_q;
    assign toff = 12'(avs_address - `WCS_TAB_OFS);
    assign ti   = toff[11:3];
    assign thit = (avs_address >= `WCS_TAB_OFS) && (ti < 9'(NUM_SCHED));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  be);
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                o[8*i +: 8] = n[8*i +: 8];
        end
        return o;
    endfunction

    // Loads a schedule and opens its squeeze interval.
    function automatic wcs_seq_state_t enter(input wcs_seq_state_t a,
                                             input logic [6:0]     idx);
        wcs_pkg::wcs_sched_t sc;
        sc = wcs_pkg::wcs_sched_t'(a.tab[idx]);
        a.cur        = idx;
        a.st         = wcs_pkg::st_sqz;
        a.cnt        = sc.sqz;
        a.drv.valves = sc.valves;
        return a;
    endfunction

    // Ends a sequence: valves drop and the display settles.
    function automatic wcs_seq_state_t finish(input wcs_seq_state_t a,
                                              input logic [6:0]     sel);
        a.st         = wcs_pkg::st_idle;
        a.drv.valves = 5'h00;
        a.drv.fire   = 1'b0;
        a.dsp.flash  = 1'b0;
        if (a.series)
        begin
            a.dsp.sched = a.sfirst;
            a.series    = 1'b0;
        end
        else
        begin
            a.dsp.sched = a.ctl.ext_sel ? sel : a.key;
        end
        return a;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // Register port: one wait cycle, then the answer.
        next_s.wreq = !((avs_read || avs_write) && s.wreq);
        if ((avs_read || avs_write) && s.wreq)
        begin
            if (avs_address == `WCS_CTRL_OFS)
                next_s.rdata = {30'h0, s.ctl};
            else if (avs_address == `WCS_STAT_OFS)
                next_s.rdata = {12'h000, 4'(s.st), 1'b0, s.cur, 1'b0, s.dsp.sched};
            else if (avs_address == `WCS_KEY_OFS)
                next_s.rdata = {25'h0, s.key};
            else if (thit)
                next_s.rdata = toff[2] ? s.tab[ti][63:32] : s.tab[ti][31:0];
            else
                next_s.rdata = 32'h0000_0000;
        end
        if (avs_write && !s.wreq)
        begin
            if (avs_address == `WCS_CTRL_OFS)
                next_s.ctl = wcs_pkg::wcs_ctrl_t'(merge({30'h0, s.ctl}, avs_writedata,
                                                       avs_byteenable) & 32'h3);
            else if (avs_address == `WCS_KEY_OFS && avs_byteenable[0]
                     && avs_writedata[6:0] < 7'(NUM_SCHED))
            begin
                next_s.key = avs_writedata[6:0];
                if (s.st == wcs_pkg::st_idle && !s.ctl.ext_sel)
                begin
                    next_s.dsp.sched = avs_writedata[6:0];
                    next_s.dsp.flash = 1'b0;
                    next_s.series    = 1'b0;
                end
            end
            else if (thit && toff[2])
                next_s.tab[ti][63:32] = merge(s.tab[ti][63:32], avs_writedata, avs_byteenable);
            else if (thit)
                next_s.tab[ti][31:0] = merge(s.tab[ti][31:0], avs_writedata, avs_byteenable);
        end

        // Back-step hold timer; it saturates so the error stays until release.
        next_s.init_q = oper.init;
        next_s.bs_q   = oper.back_step_input;
        if (!oper.back_step_input)
        begin
            next_s.bs_cnt    = 32'h0000_0000;
            next_s.dsp.err06 = 1'b0;
        end
        else if (s.bs_cnt != BS_HOLD_CYC)
        begin
            next_s.bs_cnt = s.bs_cnt + 32'h0000_0001;
        end

        case (s.st)
            wcs_pkg::st_idle:
            begin
                next_s.drv.fire = 1'b0;
                if (s.ctl.ext_sel && !s.series)
                    next_s.dsp.sched = ss;
                if (s.series && oper.back_step_input)
                begin
                    if (!s.bs_q && s.dsp.sched > s.sfirst)
                        next_s.dsp.sched = 7'(s.dsp.sched - 7'h01);
                    if (s.bs_cnt == BS_HOLD_CYC - 32'h1)
                        next_s.dsp.sched = s.sfirst;
                    if (s.bs_cnt == BS_HOLD_CYC && s.dsp.sched == s.sfirst)
                        next_s.dsp.err06 = 1'b1;
                end
                if (rise)
                begin
                    next_s.first     = s.dsp.sched;
                    next_s.dsp.flash = 1'b0;
                    if (!s.series)
                        next_s.sfirst = s.dsp.sched;
                    next_s = enter(next_s, s.dsp.sched);
                end
            end
            wcs_pkg::st_sqz:
            begin
                if (s.cnt == 8'h00)
                begin
                    if (oper.press)
                    begin
                        next_s.dsp.sqz_flash = 1'b0;
                        next_s.st            = wcs_pkg::st_weld;
                        next_s.cnt           = cs.weld;
                        next_s.imp           = cs.imp;
                    end
                    else
                    begin
                        next_s.dsp.sqz_flash = 1'b1;
                        next_s.drv.fire      = 1'b0;
                    end
                end
                else
                begin
                    next_s.drv.fire = 1'b0;
                    if (oper.line_tick)
                        next_s.cnt = s.cnt - 8'h01;
                end
            end
            wcs_pkg::st_weld:
            begin
                next_s.drv.level = cs.cur;
                if (s.cnt == 8'h00)
                begin
                    // Fire is left as it was, so zero intervals add no gap.
                    if (s.imp > 8'h01)
                    begin
                        next_s.imp = s.imp - 8'h01;
                        next_s.st  = wcs_pkg::st_cool;
                        next_s.cnt = cs.cool;
                    end
                    else
                    begin
                        next_s.st  = wcs_pkg::st_hold;
                        next_s.cnt = cs.hold;
                    end
                end
                else
                begin
                    next_s.drv.fire = s.ctl.weld_en;
                    if (oper.line_tick)
                        next_s.cnt = s.cnt - 8'h01;
                end
            end
            wcs_pkg::st_cool:
            begin
                if (s.cnt == 8'h00)
                begin
                    next_s.st  = wcs_pkg::st_weld;
                    next_s.cnt = cs.weld;
                end
                else
                begin
                    next_s.drv.fire = 1'b0;
                    if (oper.line_tick)
                        next_s.cnt = s.cnt - 8'h01;
                end
            end
            wcs_pkg::st_hold:
            begin
                if (s.cnt != 8'h00)
                begin
                    next_s.drv.fire = 1'b0;
                    if (oper.line_tick)
                        next_s.cnt = s.cnt - 8'h01;
                end
                else
                begin
                    case (cs.mode)
                        `WCS_CM_REPEAT, `WCS_CM_CHAIN:
                        begin
                            next_s.st  = wcs_pkg::st_off;
                            next_s.cnt = cs.off;
                        end
                        `WCS_CM_SUCC:
                        begin
                            next_s           = finish(next_s, ss);
                            next_s.dsp.sched = nxt;
                            next_s.dsp.flash = 1'b1;
                            next_s.series    = 1'b1;
                        end
                        `WCS_CM_CSUCC:
                        begin
                            next_s.st             = wcs_pkg::st_csw;
                            next_s.drv.fire       = 1'b0;
                            next_s.dsp.hold_flash = 1'b1;
                            next_s.need_rel       = oper.init;
                        end
                        `WCS_CM_WAIT:
                        begin
                            next_s.st       = wcs_pkg::st_whw;
                            next_s.drv.fire = 1'b0;
                        end
                        default:
                        begin
                            next_s = finish(next_s, ss);
                        end
                    endcase
                end
            end
            wcs_pkg::st_off:
            begin
                if (s.cnt != 8'h00)
                begin
                    next_s.drv.fire = 1'b0;
                    if (oper.line_tick)
                        next_s.cnt = s.cnt - 8'h01;
                end
                else if (cs.mode == `WCS_CM_CHAIN)
                begin
                    next_s = enter(next_s, nxt);
                end
                else if (oper.init)
                begin
                    next_s = enter(next_s, s.first);
                end
                else
                begin
                    next_s = finish(next_s, ss);
                end
            end
            wcs_pkg::st_csw:
            begin
                next_s.drv.fire       = 1'b0;
                next_s.dsp.hold_flash = 1'b1;
                if (!oper.init)
                    next_s.need_rel = 1'b0;
                if (oper.init && !s.need_rel)
                begin
                    next_s.dsp.hold_flash = 1'b0;
                    if (s.cur != s.first)
                        next_s = enter(next_s, s.first);
                    else
                        next_s = enter(next_s, nxt);
                end
            end
            wcs_pkg::st_whw:
            begin
                next_s.drv.fire = 1'b0;
                if (oper.aux_initiation_first)
                begin
                    next_s.first = `WCS_AUX_A;
                    next_s       = enter(next_s, `WCS_AUX_A);
                end
                else if (oper.aux_initiation_second)
                begin
                    next_s.first = `WCS_AUX_B;
                    next_s       = enter(next_s, `WCS_AUX_B);
                end
            end
            default:
            begin
                next_s = finish(next_s, ss);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            s <= S_RST;
        else
            s <= next_s;
    end

    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.wreq;
    assign drive           = s.drv;
    assign disp            = s.dsp;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    weld_fire_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_weld && s.cnt != 8'h00 |=> drive.fire == $past(s.ctl.weld_en))
        else $error("weld interval without current request");

    hold_valve_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_hold && s.cnt != 8'h00 |=> !drive.fire && drive.valves == $past(cs.valves))
        else $error("hold interval drives current or drops valves");

    nonrep_end_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_hold && s.cnt == 8'h00 && cs.mode == `WCS_CM_NONREP
        |=> s.st == wcs_pkg::st_idle && drive.valves == 5'h00)
        else $error("non-repeat end keeps valves");

    press_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_sqz && s.cnt == 8'h00 && !oper.press
        |=> s.st == wcs_pkg::st_sqz && disp.sqz_flash && !drive.fire)
        else $error("weld began with pressure switch open");

    repeat_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_off && s.cnt == 8'h00 && cs.mode == `WCS_CM_REPEAT && oper.init
        |=> s.st == wcs_pkg::st_sqz && s.cur == $past(s.first))
        else $error("repeat did not restart");

    chain_next_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_off && s.cnt == 8'h00 && cs.mode == `WCS_CM_CHAIN
        |=> s.st == wcs_pkg::st_sqz && s.cur == $past(nxt))
        else $error("chain did not advance");

    succ_disp_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_hold && s.cnt == 8'h00 && cs.mode == `WCS_CM_SUCC
        |=> disp.sched == $past(nxt) && disp.flash && s.st == wcs_pkg::st_idle)
        else $error("successive display not advanced");

    csucc_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_hold && s.cnt == 8'h00 && cs.mode == `WCS_CM_CSUCC
        |=> s.st == wcs_pkg::st_csw && disp.hold_flash && drive.valves == $past(drive.valves))
        else $error("conditional wait not entered");

    csucc_rel_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_csw && s.need_rel && oper.init |=> s.st == wcs_pkg::st_csw)
        else $error("held initiation continued the sequence");

    bs_err_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(disp.err06) |-> disp.sched == s.sfirst && oper.back_step_input)
        else $error("back-step error away from series start");

    gapless_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s.st == wcs_pkg::st_hold && s.cnt == 8'h00 && drive.fire |=> drive.fire || s.st == wcs_pkg::st_idle
        || s.st == wcs_pkg::st_csw || s.st == wcs_pkg::st_whw)
        else $error("zero hold broke current");

endmodule

`default_nettype wire

// ### verification/wcs_machine.sv
// Machine side model: line cycle tick and pressure switch.
// Assumes the head closes a fixed delay after any valve is energized.
`timescale 1ns/100ps
`default_nettype none
module wcs_machine (
    // Clock and valves
    input  wire logic       mclk,
    input  wire logic [4:0] valves,
    // Switch outputs
    output logic            press,
    output logic            line_tick
);
    logic [3:0] div = 4'h0;
    logic [5:0] dly = 6'h00;
    // A short line cycle keeps the run brief; the sequencer only counts ticks.
    // The switch closes well after a short squeeze, so the pressure wait is seen.
    always @(posedge mclk)
    begin
        div <= div + 4'h1;
        line_tick <= (div == 4'hF);
        if (!(|valves))
            dly <= 6'h00;
        else if (dly != 6'h3F)
            dly <= dly + 6'h01;
        press <= (dly == 6'h3F);
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the weld sequencer.
// Assumes the machine model supplies ticks and the pressure switch.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, init = 1'b0, bs = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wd = 32'h0, rdat, q;
    logic wreq, press, tick;
    wcs_pkg::wcs_drive_t drive;
    wcs_pkg::wcs_disp_t disp;
    int error_cnt = 0, check_count = 0;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} wcs_row_t;
    wcs_row_t rows [4] = '{'{12'h000, 32'h3, 32'h3}, '{12'h008, 32'h5, 32'h5},
                       '{12'h008, 32'h64, 32'h5}, '{12'h00C, 32'h7, 32'h0}};
    always #2.5 mclk = ~mclk;
    wcs_machine mach (.mclk(mclk), .valves(drive.valves), .press(press), .line_tick(tick));
    wcs_sequencer #(.BS_HOLD_CYC(32'd50)) DUT (.mclk(mclk), .rst_b(rst_b), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wreq), .drive(drive), .disp(disp),
        .oper({init, press, bs, 4'h0, tick}));
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        while (wreq !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                error_cnt++;
                end_of_test();
            end
            @(posedge mclk);
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wt(input logic on, input int k);
        int n = 0;
        while ((k == 0 ? |drive.valves : k == 1 ? drive.fire : disp.hold_flash) !== on)
        begin
            n++;
            if (n > 3000)
            begin
                error_cnt++;
                end_of_test();
            end
            @(posedge mclk);
        end
    endtask
    task automatic run;
        init <= 1'b1;
        wt(1'b1, 0);
        init <= 1'b0;
        wt(1'b0, 0);
        repeat (2) @(posedge mclk);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        chk({drive, disp}, '0);
        bus(1'b0, 12'h008, 32'h0);
        chk(q, 32'h0);
        foreach (rows[i])
        begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk(q, rows[i].e);
        end
        // Schedules 1 to 3: plain spot, then a two-step successive series.
        bus(1'b1, 12'h408, 32'h00010102);
        bus(1'b1, 12'h40C, 32'h03400100);
        bus(1'b1, 12'h410, 32'h00010102);
        bus(1'b1, 12'h414, 32'h61400100);
        bus(1'b1, 12'h418, 32'h00010102);
        bus(1'b1, 12'h41C, 32'h01400100);
        // Schedules 4 to 8: gapless chain pair, repeat, conditional successive pair.
        bus(1'b1, 12'h420, 32'h00000102);
        bus(1'b1, 12'h424, 32'h41400100);
        bus(1'b1, 12'h428, 32'h00010200);
        bus(1'b1, 12'h42C, 32'h01400100);
        bus(1'b1, 12'h430, 32'h01010102);
        bus(1'b1, 12'h434, 32'h21400100);
        bus(1'b1, 12'h438, 32'h00010102);
        bus(1'b1, 12'h43C, 32'h81400100);
        bus(1'b1, 12'h440, 32'h00010102);
        bus(1'b1, 12'h444, 32'h01400100);
        bus(1'b1, 12'h000, 32'h1);
        bus(1'b1, 12'h008, 32'h1);
        init <= 1'b1;
        wt(1'b1, 0);
        chk(drive.valves, 5'h03);
        chk(drive.fire, 1'b0);
        repeat (45) @(posedge mclk);
        chk(disp.sqz_flash, 1'b1);
        chk(drive.fire, 1'b0);
        wt(1'b1, 1);
        chk(drive.level, 8'h40);
        init <= 1'b0;
        wt(1'b0, 0);
        chk(drive.fire, 1'b0);
        bus(1'b1, 12'h008, 32'h2);
        run();
        chk(disp.sched, 7'h03);
        chk(disp.flash, 1'b1);
        run();
        chk(disp.sched, 7'h02);
        run();
        bs <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(disp.sched, 7'h02);
        repeat (60) @(posedge mclk);
        chk(disp.err06, 1'b1);
        bs <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(disp.err06, 1'b0);
        bus(1'b1, 12'h008, 32'h4);
        init <= 1'b1;
        wt(1'b1, 1);
        init <= 1'b0;
        repeat (20) @(posedge mclk);
        chk(drive.fire, 1'b1);
        wt(1'b0, 0);
        chk(disp.sched, 7'h04);
        bus(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0000_0504);
        bus(1'b1, 12'h008, 32'h6);
        init <= 1'b1;
        wt(1'b1, 1);
        wt(1'b0, 1);
        wt(1'b1, 1);
        init <= 1'b0;
        wt(1'b0, 0);
        bus(1'b1, 12'h008, 32'h7);
        init <= 1'b1;
        wt(1'b1, 2);
        bus(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0006_0707);
        chk(drive.valves, 5'h01);
        init <= 1'b0;
        repeat (2) @(posedge mclk);
        init <= 1'b1;
        wt(1'b0, 2);
        init <= 1'b0;
        wt(1'b0, 0);
        chk(disp.sched, 7'h07);
        bus(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0000_0807);
        init <= 1'b1;
        wt(1'b1, 0);
        rst_b <= 1'b0;
        init <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({drive, disp}, '0);
        chk(wreq, 1'b1);
        rst_b <= 1'b1;
        bus(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
